// ---- core/pipelined_sram_write_addr_ctrl.sv ----
// Pipelined burst SRAM core: address capture, burst counter, byte writes.
`timescale 1ns/1ps
`default_nettype none
module pipelined_sram_write_addr_ctrl (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire sram_pkg::sram_ctrl_t ctrl_i,
    input wire logic [sram_pkg::ADDR_W-1:0] addr_i,
    input wire logic [sram_pkg::DATA_W-1:0] wdata_i,
    input wire logic burst_order_strap_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic [sram_pkg::DATA_W-1:0] rdata_o,
    output logic rdata_valid_o,
    output logic tdo_o,
    output logic tdo_oe_o
);
    localparam int AW = sram_pkg::ADDR_W;
    localparam int BL = sram_pkg::BASE_LO;
    localparam int LW = sram_pkg::LANE_W;

    // One word per address; the array is not cleared by reset.
    logic [sram_pkg::DATA_W-1:0] mem [sram_pkg::DEPTH];

    logic linear, next_linear, active, next_active;
    logic [AW-1:BL] base, next_base;
    logic [1:0] start, next_start, count, next_count, cur_low, next_low;
    logic enabled, proc_take, ctrl_take, capture, deselect, proc_capture;
    logic [sram_pkg::LANES-1:0] lane_sel, lane_we;
    logic [AW-1:0] access_addr;
    logic [sram_pkg::DATA_W-1:0] rdata, next_rdata;
    logic rvalid, next_rvalid, access_read;

    // Address qualification; the processor strobe outranks the other.
    assign enabled = !ctrl_i.chip_sel_primary_n && ctrl_i.chip_sel_expand_hi
        && !ctrl_i.chip_sel_expand_lo_n;
    assign proc_take = !ctrl_i.addr_strobe_proc_n
        && !ctrl_i.chip_sel_primary_n;
    assign ctrl_take = !ctrl_i.addr_strobe_ctrl_n && !proc_take;
    assign capture = (proc_take || ctrl_take) && enabled;
    assign deselect = ctrl_take && !enabled;
    assign proc_capture = proc_take && enabled;

    // Burst order: interleaved flips bits, linear counts up and wraps.
    function automatic logic [1:0] burst_low(input logic lin,
        input logic [1:0] s, input logic [1:0] c);
        burst_low = lin ? 2'(s + c) : (s ^ c);
    endfunction : burst_low

    assign cur_low = burst_low(linear, start, count);
    assign next_low = burst_low(next_linear, next_start, next_count);

    // Address and burst state for the access at this edge.
    always_comb
    begin
        next_linear = linear;
        next_active = active;
        next_base = base;
        next_start = start;
        next_count = count;
        // The strap is caught only during reset, so it must stay put.
        if (srst_i)
            next_linear = !burst_order_strap_i;
        if (capture)
        begin
            next_active = 1'b1;
            next_base = addr_i[AW-1:BL];
            next_start = addr_i[sram_pkg::ADDR_BIT_ONE:
                sram_pkg::ADDR_BIT_ZERO];
            next_count = sram_pkg::BURST_RST;
        end
        else if (deselect)
            next_active = 1'b0;
        else if (active && !ctrl_i.burst_advance_n)
            next_count = 2'(count + sram_pkg::BURST_STEP);
    end

    always_ff @(posedge clk_i)
    begin
        linear <= next_linear;
        if (srst_i)
        begin
            active <= 1'b0;
            base <= sram_pkg::BASE_RST;
            start <= sram_pkg::BURST_RST;
            count <= sram_pkg::BURST_RST;
        end
        else
        begin
            active <= next_active;
            base <= next_base;
            start <= next_start;
            count <= next_count;
        end
    end

    // Lane write decode; a processor-strobe start is always a read cycle.
    assign lane_sel = {!ctrl_i.lane1_write_sel_n, !ctrl_i.lane0_write_sel_n};
    always_comb
    begin
        lane_we = sram_pkg::LANES_NONE;
        if (next_active && !proc_capture && !srst_i)
        begin
            if (!ctrl_i.all_lanes_write_n)
                lane_we = sram_pkg::LANES_ALL;
            else if (!ctrl_i.lane_write_enable_n)
                lane_we = lane_sel;
        end
    end
    assign access_addr = {next_base, next_low};
    assign access_read = next_active && !srst_i
        && (lane_we == sram_pkg::LANES_NONE);

    // Lane-wise array write at the access address.
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < sram_pkg::LANES; i++)
        begin
            if (lane_we[i])
                mem[access_addr][i*LW +: LW] <= wdata_i[i*LW +: LW];
        end
    end

    // Read pipeline: the word is registered at the same edge that takes its address.
    always_comb
    begin
        next_rdata = rdata;
        next_rvalid = access_read;
        if (access_read)
            next_rdata = mem[access_addr];
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rdata <= sram_pkg::DATA_RST;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign rdata_o = rdata;
    assign rdata_valid_o = rvalid;

    // Test port logic samples its pins from the system clock.
    tap_ctrl u_tap (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tck_i(tck_i),
        .tms_i(tms_i),
        .tdi_i(tdi_i),
        .tdo_o(tdo_o),
        .tdo_oe_o(tdo_oe_o)
    );

    chk_addr_capture: assert property (@(posedge clk_i) disable iff (srst_i)
        (enabled && (proc_take || !ctrl_i.addr_strobe_ctrl_n))
        |=> active && base == $past(addr_i[AW-1:BL]))
        else $error("address not captured");
    chk_counter_load: assert property (@(posedge clk_i) disable iff (srst_i)
        capture |=> start == $past(addr_i[1:0]) && count == 2'h0)
        else $error("burst counter not loaded");
    chk_proc_ignored: assert property (@(posedge clk_i) disable iff (srst_i)
        (ctrl_i.chip_sel_primary_n && ctrl_i.addr_strobe_ctrl_n
        && ctrl_i.burst_advance_n) |=> $stable(base) && $stable(active))
        else $error("strobe taken while deselected");
    chk_proc_wins: assert property (@(posedge clk_i) disable iff (srst_i)
        (proc_take && enabled && !ctrl_i.addr_strobe_ctrl_n)
        |=> rdata_valid_o && $past(lane_we) == 2'h0)
        else $error("controller strobe won");
    chk_burst_step: assert property (@(posedge clk_i) disable iff (srst_i)
        (active && !capture && !deselect && !ctrl_i.burst_advance_n)
        |=> count == 2'($past(count) + 2'h1)) else $error("no burst step");
    chk_burst_order: assert property (@(posedge clk_i) disable iff (srst_i)
        cur_low == (linear ? 2'(start + count) : (start ^ count)))
        else $error("wrong burst order");
    chk_global_write: assert property (@(posedge clk_i) disable iff (srst_i)
        (next_active && !proc_capture && !ctrl_i.all_lanes_write_n)
        |-> lane_we == 2'h3) else $error("global write lost lanes");
    chk_lane_write: assert property (@(posedge clk_i) disable iff (srst_i)
        (next_active && !proc_capture && ctrl_i.all_lanes_write_n)
        |-> lane_we == (ctrl_i.lane_write_enable_n ? 2'h0 : lane_sel))
        else $error("lane write mismatch");
    chk_plain_read: assert property (@(posedge clk_i) disable iff (srst_i)
        (next_active && ctrl_i.all_lanes_write_n
        && (ctrl_i.lane_write_enable_n || lane_sel == 2'h0))
        |=> rdata_valid_o) else $error("read cycle dropped");
    chk_read_pipe: assert property (@(posedge clk_i) disable iff (srst_i)
        access_read |=> rdata_o == $past(mem[access_addr]))
        else $error("read data mismatch");
    cov_proc_read: cover property (@(posedge clk_i) proc_capture ##1 rvalid);
    cov_burst_four: cover property (@(posedge clk_i)
        capture ##1 (!ctrl_i.burst_advance_n && active) [*3]);
    cov_global_wr: cover property (@(posedge clk_i) lane_we == 2'h3);
endmodule : pipelined_sram_write_addr_ctrl
`default_nettype wire

// ---- core/sram_pkg.sv ----
// Shared constants, pin bundle and test-port states for the burst SRAM core.
package sram_pkg;
    // Array geometry: 512K words of two nine-bit lanes.
    localparam int ADDR_W = 19;
    localparam int DEPTH = 524288;
    localparam int LANES = 2;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int ADDR_BIT_ZERO = 0;
    localparam int ADDR_BIT_ONE = 1;
    localparam int BASE_LO = 2;
    // Values after reset, the burst step and the lane masks.
    localparam logic [1:0] BURST_RST = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;
    localparam logic [LANES-1:0] LANES_NONE = 2'h0;
    localparam logic [LANES-1:0] LANES_ALL = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
    localparam logic [ADDR_W-1:BASE_LO] BASE_RST = 17'h0_0000;
    // Test port: pin synchroniser length, instruction width and codes.
    localparam int JTAG_SYNC_LEN = 3;
    localparam int IR_W = 3;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
    // Identity value is arbitrary and names no maker.
    localparam logic [31:0] IDCODE_VALUE = 32'h0000_0001;
    localparam logic [2:0] SYNC_RST = 3'h0;

    // Synchronous control pins sampled on every rising clock edge.
    typedef struct packed {
        logic addr_strobe_proc_n;
        logic addr_strobe_ctrl_n;
        logic burst_advance_n;
        logic chip_sel_primary_n;
        logic chip_sel_expand_hi;
        logic chip_sel_expand_lo_n;
        logic lane_write_enable_n;
        logic all_lanes_write_n;
        logic lane1_write_sel_n;
        logic lane0_write_sel_n;
    } sram_ctrl_t;

    // Boundary-scan controller states.
    typedef enum logic [15:0] {
        TS_RESET = 16'h0001, TS_IDLE = 16'h0002, TS_SEL_DR = 16'h0004,
        TS_CAP_DR = 16'h0008, TS_SH_DR = 16'h0010, TS_EX1_DR = 16'h0020,
        TS_PA_DR = 16'h0040, TS_EX2_DR = 16'h0080, TS_UP_DR = 16'h0100,
        TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR = 16'h0800,
        TS_EX1_IR = 16'h1000, TS_PA_IR = 16'h2000, TS_EX2_IR = 16'h4000,
        TS_UP_IR = 16'h8000
    } tap_state_t;
endpackage : sram_pkg

// ---- core/tap_ctrl.sv ----
// Boundary-scan test access port sampled from the system clock.
`timescale 1ns/1ps
`default_nettype none
module tap_ctrl (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o
);
    logic [2:0] sync1, sync2, sync3, lvl, next_lvl;
    logic tck_rise, tck_fall, tms, tdi;
    sram_pkg::tap_state_t state, next_state;
    logic [sram_pkg::IR_W-1:0] ir, ir_sh, next_ir, next_ir_sh;
    logic [31:0] dr_sh, next_dr_sh;
    logic tdo, next_tdo, oe, next_oe;

    // Local names for the controller states; nothing is imported.
    localparam sram_pkg::tap_state_t TS_RESET = sram_pkg::TS_RESET;
    localparam sram_pkg::tap_state_t TS_IDLE = sram_pkg::TS_IDLE;
    localparam sram_pkg::tap_state_t TS_SEL_DR = sram_pkg::TS_SEL_DR;
    localparam sram_pkg::tap_state_t TS_CAP_DR = sram_pkg::TS_CAP_DR;
    localparam sram_pkg::tap_state_t TS_SH_DR = sram_pkg::TS_SH_DR;
    localparam sram_pkg::tap_state_t TS_EX1_DR = sram_pkg::TS_EX1_DR;
    localparam sram_pkg::tap_state_t TS_PA_DR = sram_pkg::TS_PA_DR;
    localparam sram_pkg::tap_state_t TS_EX2_DR = sram_pkg::TS_EX2_DR;
    localparam sram_pkg::tap_state_t TS_UP_DR = sram_pkg::TS_UP_DR;
    localparam sram_pkg::tap_state_t TS_SEL_IR = sram_pkg::TS_SEL_IR;
    localparam sram_pkg::tap_state_t TS_CAP_IR = sram_pkg::TS_CAP_IR;
    localparam sram_pkg::tap_state_t TS_SH_IR = sram_pkg::TS_SH_IR;
    localparam sram_pkg::tap_state_t TS_EX1_IR = sram_pkg::TS_EX1_IR;
    localparam sram_pkg::tap_state_t TS_PA_IR = sram_pkg::TS_PA_IR;
    localparam sram_pkg::tap_state_t TS_EX2_IR = sram_pkg::TS_EX2_IR;
    localparam sram_pkg::tap_state_t TS_UP_IR = sram_pkg::TS_UP_IR;

    // A pin level counts once the second and third stages agree.
    assign next_lvl = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & lvl);
    assign tck_rise = next_lvl[2] & ~lvl[2];
    assign tck_fall = ~next_lvl[2] & lvl[2];
    assign tms = lvl[1];
    assign tdi = lvl[0];

    // Next state, shift paths and output on the test clock edges.
    always_comb
    begin
        next_state = state;
        next_ir = ir;
        next_ir_sh = ir_sh;
        next_dr_sh = dr_sh;
        next_tdo = tdo;
        next_oe = oe;
        if (tck_rise)
        begin
            unique case (state)
                TS_RESET: next_state = tms ? TS_RESET : TS_IDLE;
                TS_IDLE: next_state = tms ? TS_SEL_DR : TS_IDLE;
                TS_SEL_DR: next_state = tms ? TS_SEL_IR : TS_CAP_DR;
                TS_CAP_DR: next_state = tms ? TS_EX1_DR : TS_SH_DR;
                TS_SH_DR: next_state = tms ? TS_EX1_DR : TS_SH_DR;
                TS_EX1_DR: next_state = tms ? TS_UP_DR : TS_PA_DR;
                TS_PA_DR: next_state = tms ? TS_EX2_DR : TS_PA_DR;
                TS_EX2_DR: next_state = tms ? TS_UP_DR : TS_SH_DR;
                TS_UP_DR: next_state = tms ? TS_SEL_DR : TS_IDLE;
                TS_SEL_IR: next_state = tms ? TS_RESET : TS_CAP_IR;
                TS_CAP_IR: next_state = tms ? TS_EX1_IR : TS_SH_IR;
                TS_SH_IR: next_state = tms ? TS_EX1_IR : TS_SH_IR;
                TS_EX1_IR: next_state = tms ? TS_UP_IR : TS_PA_IR;
                TS_PA_IR: next_state = tms ? TS_EX2_IR : TS_PA_IR;
                TS_EX2_IR: next_state = tms ? TS_UP_IR : TS_SH_IR;
                TS_UP_IR: next_state = tms ? TS_SEL_DR : TS_IDLE;
            endcase
            // Any code other than the identity reads as the one-bit bypass.
            if (state == TS_RESET)
                next_ir = sram_pkg::IR_IDCODE;
            if (state == TS_CAP_IR)
                next_ir_sh = sram_pkg::IR_CAPTURE;
            if (state == TS_SH_IR)
                next_ir_sh = {tdi, ir_sh[sram_pkg::IR_W-1:1]};
            if (state == TS_UP_IR)
                next_ir = ir_sh;
            if (state == TS_CAP_DR)
                next_dr_sh = (ir == sram_pkg::IR_IDCODE) ?
                    sram_pkg::IDCODE_VALUE : 32'h0000_0000;
            if (state == TS_SH_DR)
                next_dr_sh = (ir == sram_pkg::IR_IDCODE) ?
                    {tdi, dr_sh[31:1]} : {31'h0000_0000, tdi};
        end
        if (tck_fall)
        begin
            next_oe = (state == TS_SH_DR) || (state == TS_SH_IR);
            next_tdo = (state == TS_SH_IR) ? ir_sh[0] : dr_sh[0];
        end
    end

    // Register stage; reset parks the controller in its reset state.
    always_ff @(posedge clk_i)
    begin
        sync1 <= {tck_i, tms_i, tdi_i};
        sync2 <= sync1;
        sync3 <= sync2;
        if (srst_i)
        begin
            lvl <= sram_pkg::SYNC_RST;
            state <= TS_RESET;
            ir <= sram_pkg::IR_IDCODE;
            ir_sh <= sram_pkg::IR_CAPTURE;
            dr_sh <= 32'h0000_0000;
            tdo <= 1'b0;
            oe <= 1'b0;
        end
        else
        begin
            lvl <= next_lvl;
            state <= next_state;
            ir <= next_ir;
            ir_sh <= next_ir_sh;
            dr_sh <= next_dr_sh;
            tdo <= next_tdo;
            oe <= next_oe;
        end
    end

    assign tdo_o = tdo;
    assign tdo_oe_o = oe;

    chk_tdo_on_fall: assert property (@(posedge clk_i) disable iff (srst_i)
        $changed(tdo) |-> $past(tck_fall)) else $error("tdo moved off fall");
    chk_state_on_rise: assert property (@(posedge clk_i) disable iff (srst_i)
        (state != $past(state)) |-> $past(tck_rise))
        else $error("state moved off rise");
    chk_tms_reset: assert property (@(posedge clk_i) disable iff (srst_i)
        (tck_rise && tms && state == TS_SEL_IR) |=> state == TS_RESET)
        else $error("no reset entry");
    cov_ir_update: cover property (@(posedge clk_i) state == TS_UP_IR);
endmodule : tap_ctrl
`default_nettype wire

// ---- tb/sram_host_model.sv ----
// Host-side model that drives the synchronous SRAM pins and the test port.
`timescale 1ns/1ps
`default_nettype none
module sram_host_model (
    input wire logic clk_i,
    input wire logic tdo_i,
    output var sram_pkg::sram_ctrl_t ctrl_o,
    output logic [sram_pkg::ADDR_W-1:0] addr_o,
    output logic [sram_pkg::DATA_W-1:0] wdata_o,
    output logic strap_o,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    // Pins start idle with the device selected and no strobe asserted.
    initial
    begin
        ctrl_o = sram_pkg::sram_ctrl_t'(10'h3AF);
        addr_o = 19'h0_0000;
        wdata_o = 18'h0_0000;
        strap_o = 1'b0;
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One bus cycle; lane enable and lane selects travel in one word.
    task automatic put(input logic [9:0] c,
                       input logic [sram_pkg::ADDR_W-1:0] a,
                       input logic [sram_pkg::DATA_W-1:0] d);
        @(posedge clk_i);
        ctrl_o <= sram_pkg::sram_ctrl_t'(c);
        addr_o <= a;
        // Without a write the data lines are not ours, so scramble them.
        if (c[2] && c[3])
            wdata_o <= ~wdata_o;
        else
            wdata_o <= d;
    endtask : put

    // The strap is only moved while the device is held in reset.
    task automatic set_strap(input logic v);
        @(posedge clk_i);
        strap_o <= v;
    endtask : set_strap

    // One test clock period; the clock stands still low between steps.
    task automatic tap_step(input logic m, input logic i, output logic o);
        @(posedge clk_i);
        tms_o <= m;
        tdi_o <= i;
        repeat (8) @(posedge clk_i);
        o = tdo_i;
        tck_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        tck_o <= 1'b0;
    endtask : tap_step
endmodule : sram_host_model
`default_nettype wire

// ---- tb/tb_pipelined_sram_write_addr_ctrl.sv ----
// Self-checking bench for the pipelined burst SRAM control core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
module tb_pipelined_sram_write_addr_ctrl;
    // Control words, field order as in the package struct.
    localparam logic [9:0] RD = 10'h2AF;
    localparam logic [9:0] GW = 10'h2AB;
    localparam logic [9:0] LANE0 = 10'h2A6;
    localparam logic [9:0] SELNOEN = 10'h2AE;
    localparam logic [9:0] BURST_ADVANCE_N = 10'h32F;
    localparam logic [9:0] DESEL = 10'h28F;
    localparam logic [9:0] BOTH = 10'h0AB;
    localparam logic [9:0] PROCHI = 10'h1EB;
    localparam logic [9:0] NOEN = 10'h2BB;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    sram_pkg::sram_ctrl_t ctrl;
    logic [sram_pkg::ADDR_W-1:0] addr;
    logic [sram_pkg::DATA_W-1:0] wdata;
    logic [sram_pkg::DATA_W-1:0] rdata;
    logic strap, tck, tms, tdi, valid, tdo, tdo_oe;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    // 20 MHz system clock.
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    sram_host_model host (.clk_i(clk_i), .tdo_i(tdo), .ctrl_o(ctrl),
        .addr_o(addr), .wdata_o(wdata), .strap_o(strap), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi));

    pipelined_sram_write_addr_ctrl DUT (.clk_i(clk_i), .srst_i(srst_i),
        .ctrl_i(ctrl), .addr_i(addr), .wdata_i(wdata),
        .burst_order_strap_i(strap), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .rdata_o(rdata), .rdata_valid_o(valid), .tdo_o(tdo),
        .tdo_oe_o(tdo_oe));

    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // A hang is cut off at 20000 cycles, far beyond the whole plan of under a thousand.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    // Reset lasts 17 edges; the strap is moved only inside it.
    task automatic reset_with(input logic s);
        @(posedge clk_i);
        srst_i <= 1'b1;
        host.set_strap(s);
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        @(negedge clk_i);
        `CHK(valid, 1'b0)
        `CHK(rdata, 18'h0_0000)
        `CHK(tdo_oe, 1'b0)
    endtask : reset_with

    // Write access by control word, followed by a deselect.
    task automatic wr(input logic [9:0] c, input logic [18:0] a,
                      input logic [17:0] d);
        host.put(c, a, d);
        host.put(DESEL, 19'h0_0000, 18'h0_0000);
    endtask : wr

    // A read answers at its capture edge; the check follows at the next fall.
    task automatic rd_chk(input logic [18:0] a, input logic [17:0] e);
        host.put(RD, a, 18'h0_0000);
        host.put(DESEL, 19'h0_0000, 18'h0_0000);
        @(negedge clk_i);
        `CHK(valid, 1'b1)
        `CHK(rdata, e)
    endtask : rd_chk

    // Global and lane writes, including selects without lane enable.
    task automatic write_lanes();
        wr(GW, 19'h0_0010, 18'h2_A955);
        rd_chk(19'h0_0010, 18'h2_A955);
        wr(LANE0, 19'h0_0010, 18'h1_5C0F);
        rd_chk(19'h0_0010, 18'h2_A80F);
        wr(SELNOEN, 19'h0_0010, 18'h3_FFFF);
        rd_chk(19'h0_0010, 18'h2_A80F);
    endtask : write_lanes

    // Strobe priority and refused captures leave the word untouched.
    task automatic strobes();
        logic [9:0] bad [2] = '{PROCHI, NOEN};
        host.put(BOTH, 19'h0_0010, 18'h0_0000);
        host.put(DESEL, 19'h0_0000, 18'h0_0000);
        @(negedge clk_i);
        `CHK(valid, 1'b1)
        foreach (bad[i])
        begin
            host.put(bad[i], 19'h0_0010, 18'h0_0000);
            host.put(DESEL, 19'h0_0000, 18'h0_0000);
            @(negedge clk_i);
            `CHK(valid, 1'b0)
        end
        rd_chk(19'h0_0010, 18'h2_A80F);
    endtask : strobes

    // Both ends of the word range stay distinct locations.
    task automatic addr_range();
        wr(GW, 19'h7_FFFF, 18'h1_2345);
        wr(GW, 19'h0_0000, 18'h0_6789);
        rd_chk(19'h7_FFFF, 18'h1_2345);
        rd_chk(19'h0_0000, 18'h0_6789);
    endtask : addr_range

    // Burst from low bits 01; order depends on the strap.
    task automatic burst(input logic s);
        logic [1:0] lo;
        reset_with(s);
        for (int k = 0; k < 4; k++)
            wr(GW, 19'h0_0040 + 19'(k), 18'h0_0100 + 18'(k));
        host.put(RD, 19'h0_0041, 18'h0_0000);
        for (int i = 0; i < 4; i++)
        begin
            host.put(BURST_ADVANCE_N, 19'h0_0000, 18'h0_0000);
            @(negedge clk_i);
            lo = s ? (2'h1 ^ 2'(i)) : (2'h1 + 2'(i));
            `CHK(rdata, 18'h0_0100 + 18'(lo))
        end
        host.put(DESEL, 19'h0_0000, 18'h0_0000);
    endtask : burst

    // Identity register is shifted out LSB first, changing on the fall.
    task automatic tap_idcode();
        logic o;
        logic [31:0] got;
        logic [8:0] seq = 9'h05F;
        for (int i = 0; i < 9; i++)
            host.tap_step(seq[i], 1'b0, o);
        repeat (8) @(posedge clk_i);
        `CHK(tdo_oe, 1'b1)
        for (int i = 0; i < 32; i++)
        begin
            host.tap_step(i == 31, 1'b1, o);
            got[i] = o;
        end
        `CHK(got, sram_pkg::IDCODE_VALUE)
    endtask : tap_idcode

    // Main sequence.
    initial
    begin
        reset_with(1'b0);
        write_lanes();
        strobes();
        addr_range();
        burst(1'b0);
        burst(1'b1);
        tap_idcode();
        print_verdict();
    end
endmodule : tb_pipelined_sram_write_addr_ctrl
`default_nettype wire
